/* File: hw/pcs_clock_synth.sv */
`timescale 1ns/1ps
`include "pcs_params.svh"

// Function
// - eight independent loops, each with own dividers, reset, feedback, lock
// - loop i takes reference from pin i, primary drives net i
// - enabled secondary of loop i (0 to 6) drives net i+1
// - loop reset chosen between fabric signal and dedicated pin
// - feedback chosen between dedicated pin and tap of own driven clock
// - lock of each loop goes straight out to fabric
// - input divider divides, feedback divider multiplies: out = ref*N/M
// - post divider brings oscillator down to primary output
// - secondary divider used only when secondary enabled, divides primary
// - programmable delay in reference or feedback path skews output
// - each net sourced from its pin or from the synthesis circuit

module pcs_clock_synth (
    input  wire logic                                       clk,
    input  wire logic                                       sys_rst,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  global_clock_pin,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  net_src_synth,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  secondary_enable,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  rst_pin_sel,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  loop_rst_fabric,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  loop_rst_pin,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  fbk_pin_sel,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  loop_feedback_in,
    input  wire pcs_pkg::pcs_ratio_t [`PCS_NUM_LOOPS-1:0]   div_in_ratio,
    input  wire pcs_pkg::pcs_ratio_t [`PCS_NUM_LOOPS-1:0]   div_fb_ratio,
    input  wire pcs_pkg::pcs_ratio_t [`PCS_NUM_LOOPS-1:0]   div_post_ratio,
    input  wire pcs_pkg::pcs_ratio_t [`PCS_NUM_LOOPS-1:0]   div_sec_ratio,
    input  wire logic [`PCS_NUM_LOOPS-1:0]                  delay_on_fb,
    input  wire pcs_pkg::pcs_dly_t [`PCS_NUM_LOOPS-1:0]     delay_taps,
    output logic [`PCS_NUM_LOOPS-1:0]                       global_net,
    output logic [`PCS_NUM_LOOPS-1:0]                       loop_lock
);
    import pcs_pkg::*;

    logic [`PCS_NUM_LOOPS-1:0] pin_q;
    logic [`PCS_NUM_LOOPS-1:0] fbk_pin_q;
    logic [`PCS_NUM_LOOPS-1:0] prim_q;
    logic [`PCS_NUM_LOOPS-1:0] sec_q;

    // ------------------------------------------------------------
    // pin history for edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_q     <= '0;
            fbk_pin_q <= '0;
        end
        else
        begin
            pin_q     <= global_clock_pin;
            fbk_pin_q <= loop_feedback_in;
        end
    end

    // ------------------------------------------------------------
    // loop instances
    // ------------------------------------------------------------
    for (genvar i = 0; i < `PCS_NUM_LOOPS; i++)
    begin : g_loop
        pcs_div_if ref_if ();
        pcs_div_if fb_if ();
        pcs_div_if post_if ();
        pcs_div_if sec_if ();

        logic                     loop_rst;
        logic                     ref_raw;
        logic                     fb_raw;
        logic                     dly_in;
        logic                     dly_out;
        logic                     ref_tick;
        logic                     fb_tick;
        logic                     bad_ref;
        logic                     bad_fb;
        logic                     vco_tick;
        logic                     use_sec;
        logic [`PCS_DLY_DEPTH-1:0] dly_q;
        logic                     last_fb_q;
        pcs_good_t                good_q;
        pcs_per_t                 per_q;
        pcs_per_t                 cnt_q;
        pcs_lock_e                st_q;

        assign loop_rst = sys_rst | (rst_pin_sel[i] ? loop_rst_pin[i]
                                                    : loop_rst_fabric[i]);

        assign ref_raw = pcs_rise(global_clock_pin[i], pin_q[i]);
        // internal tap follows the clock this loop puts on its own net
        assign fb_raw = fbk_pin_sel[i]
                      ? pcs_rise(loop_feedback_in[i], fbk_pin_q[i])
                      : (post_if.tick_out & ~prim_q[i]);

        // delay in feedback leads the output, in reference lags it
        assign dly_in  = delay_on_fb[i] ? fb_raw : ref_raw;
        assign dly_out = (delay_taps[i] == '0) ? dly_in
                       : dly_q[delay_taps[i] - pcs_dly_t'(1)];
        assign ref_tick = delay_on_fb[i] ? ref_raw : dly_out;
        assign fb_tick  = delay_on_fb[i] ? dly_out : fb_raw;

        always_ff @(posedge clk)
        begin
            if (loop_rst)
                dly_q <= '0;
            else
                dly_q <= {dly_q[`PCS_DLY_DEPTH-2:0], dly_in};
        end

        // input and feedback dividers set out = ref * N / M
        assign ref_if.rst     = loop_rst;
        assign ref_if.tick_in = ref_tick;
        assign ref_if.ratio   = div_in_ratio[i];
        assign fb_if.rst      = loop_rst;
        assign fb_if.tick_in  = fb_tick;
        assign fb_if.ratio    = div_fb_ratio[i];

        pcs_divider u_ref_div (.clk(clk), .port(ref_if.unit));
        pcs_divider u_fb_div  (.clk(clk), .port(fb_if.unit));

        // bang-bang detector: two of a kind in a row means off frequency
        assign bad_ref = ref_if.tick_out & ~fb_if.tick_out & ~last_fb_q;
        assign bad_fb  = fb_if.tick_out & ~ref_if.tick_out & last_fb_q;

        always_ff @(posedge clk)
        begin
            if (loop_rst)
            begin
                last_fb_q <= 1'b0;
                per_q     <= `PCS_PER_INIT;
                good_q    <= '0;
            end
            else if (bad_ref)
            begin
                good_q <= '0;
                if (per_q > `PCS_PER_MIN)
                    per_q <= per_q - pcs_per_t'(1);
            end
            else if (bad_fb)
            begin
                good_q <= '0;
                if (per_q < `PCS_PER_MAX)
                    per_q <= per_q + pcs_per_t'(1);
            end
            else if (ref_if.tick_out | fb_if.tick_out)
            begin
                last_fb_q <= fb_if.tick_out & ~ref_if.tick_out;
                if (good_q != `PCS_LOCK_COUNT)
                    good_q <= good_q + pcs_good_t'(1);
            end
        end

        // oscillator: one tick every per_q cycles
        always_ff @(posedge clk)
        begin
            if (loop_rst)
                cnt_q <= '0;
            else if (cnt_q == '0)
                cnt_q <= per_q - pcs_per_t'(1);
            else
                cnt_q <= cnt_q - pcs_per_t'(1);
        end
        assign vco_tick = (cnt_q == '0) & ~loop_rst;

        assign post_if.rst     = loop_rst;
        assign post_if.tick_in = vco_tick;
        assign post_if.ratio   = div_post_ratio[i];
        pcs_divider u_post_div (.clk(clk), .port(post_if.unit));

        // secondary divider held in reset while unused
        assign sec_if.rst     = loop_rst | ~secondary_enable[i];
        assign sec_if.tick_in = post_if.tick_out;
        assign sec_if.ratio   = div_sec_ratio[i];
        pcs_divider u_sec_div (.clk(clk), .port(sec_if.unit));

        always_ff @(posedge clk)
        begin
            if (loop_rst)
                prim_q[i] <= 1'b0;
            else if (post_if.tick_out)
                prim_q[i] <= ~prim_q[i];
        end

        always_ff @(posedge clk)
        begin
            if (sec_if.rst)
                sec_q[i] <= 1'b0;
            else if (sec_if.tick_out)
                sec_q[i] <= ~sec_q[i];
        end

        // ------------------------------------------------------------
        // lock state
        // ------------------------------------------------------------
        always_ff @(posedge clk)
        begin
            if (loop_rst)
                st_q <= PCS_ST_RESET;
            else
            begin
                case (st_q)
                    PCS_ST_RESET:
                        st_q <= PCS_ST_ACQUIRE;
                    PCS_ST_ACQUIRE:
                        if (good_q == `PCS_LOCK_COUNT)
                            st_q <= PCS_ST_LOCKED;
                    PCS_ST_LOCKED:
                        if (bad_ref | bad_fb)
                            st_q <= PCS_ST_ACQUIRE;
                    default:
                        st_q <= PCS_ST_RESET;
                endcase
            end
        end
        assign loop_lock[i] = (st_q == PCS_ST_LOCKED);

        // ------------------------------------------------------------
        // global net source
        // ------------------------------------------------------------
        if (i > 0)
        begin : g_nb
            assign use_sec = secondary_enable[i-1];
        end
        else
        begin : g_nb0
            assign use_sec = 1'b0;
        end

        always_ff @(posedge clk)
        begin
            if (sys_rst)
                global_net[i] <= 1'b0;
            else if (!net_src_synth[i])
                global_net[i] <= global_clock_pin[i];
            else if (use_sec)
                global_net[i] <= sec_q[(i+`PCS_NUM_LOOPS-1)%`PCS_NUM_LOOPS];
            else
                global_net[i] <= prim_q[i];
        end
    end
endmodule

/* File: hw/pcs_params.svh */
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PCS_NUM_LOOPS   8
`define PCS_RATIO_W     6
`define PCS_PER_W       12
`define PCS_DLY_W       4
`define PCS_DLY_DEPTH   16
`define PCS_GOOD_W      4

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PCS_PER_INIT    12'h040
`define PCS_PER_MIN     12'h002
`define PCS_PER_MAX     12'hFFF
`define PCS_LOCK_COUNT  4'h8

`endif

/* File: hw/pcs_pkg.sv */
`include "pcs_params.svh"

package pcs_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [`PCS_RATIO_W-1:0] pcs_ratio_t;
    typedef logic [`PCS_PER_W-1:0]   pcs_per_t;
    typedef logic [`PCS_DLY_W-1:0]   pcs_dly_t;
    typedef logic [`PCS_GOOD_W-1:0]  pcs_good_t;

    typedef enum logic [2:0] {
        PCS_ST_RESET   = 3'b001,
        PCS_ST_ACQUIRE = 3'b010,
        PCS_ST_LOCKED  = 3'b100
    } pcs_lock_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic pcs_rise(input logic cur, input logic prev);
        pcs_rise = cur & ~prev;
    endfunction

    // ratio 0 behaves as 1 so a blank setting still passes ticks
    function automatic pcs_ratio_t pcs_last(input pcs_ratio_t ratio);
        if (ratio <= pcs_ratio_t'(1))
            pcs_last = '0;
        else
            pcs_last = ratio - pcs_ratio_t'(1);
    endfunction

endpackage

/* File: hw/pcs_div_if.sv */
`timescale 1ns/1ps

interface pcs_div_if;
    logic               rst;
    logic               tick_in;
    logic               tick_out;
    pcs_pkg::pcs_ratio_t ratio;

    modport unit (input rst, input tick_in, input ratio, output tick_out);
    modport user (output rst, output tick_in, output ratio, input tick_out);
endinterface

/* File: hw/pcs_divider.sv */
`timescale 1ns/1ps

module pcs_divider (
    input  wire logic clk,
    pcs_div_if.unit   port
);
    import pcs_pkg::*;

    pcs_ratio_t cnt_q;

    // ------------------------------------------------------------
    // tick counter
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (port.rst)
        begin
            cnt_q         <= '0;
            port.tick_out <= 1'b0;
        end
        else if (port.tick_in)
        begin
            if (cnt_q >= pcs_last(port.ratio))
            begin
                cnt_q         <= '0;
                port.tick_out <= 1'b1;
            end
            else
            begin
                cnt_q         <= cnt_q + pcs_ratio_t'(1);
                port.tick_out <= 1'b0;
            end
        end
        else
        begin
            port.tick_out <= 1'b0;
        end
    end
endmodule

/* File: test/pcs_board_model.sv */
`timescale 1ns/1ps
`include "pcs_params.svh"

// ----
// board clocks: reference pins and external feedback traces
// ----
module pcs_board_model (
    input  wire logic                      clk,
    input  wire logic                      run,
    input  wire logic [`PCS_NUM_LOOPS-1:0] net,
    output logic      [`PCS_NUM_LOOPS-1:0] ref_pin,
    output logic      [`PCS_NUM_LOOPS-1:0] fb_pin
);
    logic [1:0] cnt_q;

    // stands still when stopped, period 8 cycles when running
    always_ff @(posedge clk)
    begin
        cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
        if (!run)
            ref_pin <= '0;
        else if (cnt_q == 2'h3)
            ref_pin <= ~ref_pin;
    end

    // trace back from the net pins, one cycle of board delay
    always_ff @(posedge clk)
    begin
        fb_pin <= net;
    end
endmodule

/* File: test/pcs_clock_synth_sva.sv */
`timescale 1ns/1ps
`include "pcs_params.svh"

module pcs_clock_synth_sva (
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic [`PCS_NUM_LOOPS-1:0] global_clock_pin,
    input wire logic [`PCS_NUM_LOOPS-1:0] net_src_synth,
    input wire logic [`PCS_NUM_LOOPS-1:0] secondary_enable,
    input wire logic [`PCS_NUM_LOOPS-1:0] rst_pin_sel,
    input wire logic [`PCS_NUM_LOOPS-1:0] loop_rst_fabric,
    input wire logic [`PCS_NUM_LOOPS-1:0] loop_rst_pin,
    input wire logic [`PCS_NUM_LOOPS-1:0] global_net,
    input wire logic [`PCS_NUM_LOOPS-1:0] loop_lock
);
    logic [`PCS_NUM_LOOPS-1:0] sel_rst;

    assign sel_rst = (rst_pin_sel & loop_rst_pin)
                   | (~rst_pin_sel & loop_rst_fabric);

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_clears: assert property ($fell(sys_rst) |->
        global_net == '0 && loop_lock == '0) else $error("reset left out");
    a_pin_mirror: assert property (1'b1 |=>
        ((global_net ^ $past(global_clock_pin)) & ~$past(net_src_synth))
        == '0) else $error("net not following pin");
    a_rst_lock: assert property (1'b1 |=>
        (loop_lock & $past(sel_rst)) == '0) else $error("lock in reset");
    a_lock_waits: assert property ($fell(sel_rst[0]) |->
        !loop_lock[0] [*6]) else $error("lock too early");
    a_prim_idle: assert property ((sel_rst[0] && net_src_synth[0]) [*2]
        |=> !global_net[0]) else $error("primary runs in reset");
    a_sec_idle: assert property ((sel_rst[0] && secondary_enable[0]
        && net_src_synth[1]) [*3] |=> !global_net[1])
        else $error("secondary runs in reset");
    // a loop reset or a source switch may move the net twice in a row
    a_prim_rate: assert property ($past(net_src_synth[0], 2)
        && $past(net_src_synth[0]) && net_src_synth[0]
        && !$past(sel_rst[0]) && $changed(global_net[0])
        |=> $stable(global_net[0])) else $error("primary too fast");
    a_sec_rate: assert property ($past(secondary_enable[0], 2)
        && $past(secondary_enable[0]) && secondary_enable[0]
        && $past(net_src_synth[1], 2)
        && $past(net_src_synth[1]) && net_src_synth[1]
        && !$past(sel_rst[0])
        && $changed(global_net[1]) |=> $stable(global_net[1]))
        else $error("secondary too fast");

    c_lock: cover property ($rose(loop_lock[0]));
    c_loop_rst: cover property ($fell(sel_rst[0]));
    c_sec: cover property (secondary_enable[0] && $changed(global_net[1]));
endmodule

bind pcs_clock_synth pcs_clock_synth_sva u_sva (.clk, .sys_rst,
    .global_clock_pin, .net_src_synth, .secondary_enable, .rst_pin_sel,
    .loop_rst_fabric, .loop_rst_pin, .global_net, .loop_lock);

/* File: test/pcs_clock_synth_tb.sv */
`timescale 1ns/1ps

module pcs_clock_synth_tb;
    import pcs_pkg::*;

    typedef struct packed {logic [7:0] pin, src, net;} pcs_row_s;

    logic clk = 1'b0, sys_rst, run;
    logic [7:0] pin_tb, pin_bd, fb_bd, net, lock, src, sec, rsel, rfab, rpin;
    logic [7:0] fsel, don;
    pcs_ratio_t [7:0] m_r, n_r, v_r, k_r;
    pcs_dly_t [7:0] taps;
    int fails = 0, compares = 0;
    pcs_row_s rows [5] = '{'{8'h55, 8'h00, 8'h55}, '{8'haa, 8'h00, 8'haa},
        '{8'hff, 8'h00, 8'hff}, '{8'h00, 8'h00, 8'h00},
        '{8'h3c, 8'hf0, 8'h0c}};

    always #10 clk = ~clk;

    pcs_board_model board (.clk(clk), .run(run), .net(net),
        .ref_pin(pin_bd), .fb_pin(fb_bd));

    pcs_clock_synth dut (.clk(clk), .sys_rst(sys_rst),
        .global_clock_pin(run ? pin_bd : pin_tb), .net_src_synth(src),
        .secondary_enable(sec), .rst_pin_sel(rsel), .loop_rst_fabric(rfab),
        .loop_rst_pin(rpin), .fbk_pin_sel(fsel), .loop_feedback_in(fb_bd),
        .div_in_ratio(m_r), .div_fb_ratio(n_r), .div_post_ratio(v_r),
        .div_sec_ratio(k_r), .delay_on_fb(don), .delay_taps(taps),
        .global_net(net), .loop_lock(lock));

    task automatic final_report();
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic wait_lock(input logic [7:0] m);
        int n;
        n = 0;
        // look between edges so the lock decode has settled
        while ((lock & m) !== m && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        check(n < 20000, "lock timeout");
        if (n >= 20000)
            final_report();
    endtask

    // toggles of one net over 256 cycles, ref period is 8 cycles
    task automatic count_tog(input int idx, output int t);
        logic prev;
        t = 0;
        @(negedge clk);
        prev = net[idx];
        repeat (256)
        begin
            @(negedge clk);
            if (net[idx] !== prev)
                t++;
            prev = net[idx];
        end
    endtask

    initial
    begin
        int t;
        sys_rst = 1'b1; run = 1'b0; pin_tb = '0; src = '0; sec = '0;
        rsel = 8'h02; rfab = '0; rpin = '0; fsel = 8'hf0; don = 8'haa;
        m_r = {8{6'h01}}; n_r = {8{6'h01}}; v_r = {8{6'h01}};
        k_r = {8{6'h02}}; m_r[3] = 6'h02; n_r[3] = 6'h02; v_r[2] = 6'h02;
        for (int i = 0; i < 8; i++)
            taps[i] = pcs_dly_t'(i);
        repeat (12) @(posedge clk);
        @(negedge clk);
        check(net === 8'h00 && lock === 8'h00, "reset state");
        @(posedge clk) sys_rst <= 1'b0;
        foreach (rows[r])
        begin
            @(posedge clk);
            pin_tb <= rows[r].pin;
            src <= rows[r].src;
            @(posedge clk);
            @(negedge clk);
            check((net & ~rows[r].src) === rows[r].net, "pin net");
        end
        @(posedge clk);
        run <= 1'b1;
        src <= 8'hff;
        wait_lock(8'hff);
        // a loop one step off frequency can lock briefly, let it settle
        repeat (600) @(posedge clk);
        wait_lock(8'hff);
        foreach (m_r[i])
        begin
            if (i == 0 || i == 2 || i == 3)
            begin
                count_tog(i, t);
                check(t >= 56 && t <= 72, "primary rate");
            end
        end
        @(posedge clk) sec <= 8'h01;
        count_tog(1, t);
        check(t >= 26 && t <= 38, "secondary rate");
        // loop 1 listens to its pin, so fabric reset must not touch it
        @(posedge clk) rfab <= 8'h03;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(lock[0] === 1'b0 && lock[1] === 1'b1, "fabric rst");
        @(posedge clk) rpin <= 8'h02;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(lock[1] === 1'b0, "pin reset");
        @(posedge clk);
        rfab <= '0;
        rpin <= '0;
        wait_lock(8'h03);
        final_report();
    end
endmodule
